// ---- sim/cpu_req_model.sv ----
// Model of the instruction datapath that presents requests to the mapper.
// Assumes the bench hands it at most one command per cycle on cmd.
`timescale 1ns/10ps
module cpu_req_model (
    input wire logic clock,
    input wire seg_map_pkg::mem_req_t cmd,
    output seg_map_pkg::mem_req_t req
);
    import seg_map_pkg::*;
    mem_req_t last_q = '0;
    // Idle fields show the inverse of the last request, so a design that
    // reads them without valid cannot pass by luck.
    always_comb begin
        req = cmd;
        if (!cmd.valid) begin
            req = mem_req_t'(~last_q);
            req.valid = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (cmd.valid) begin
            last_q <= cmd;
        end
    end
endmodule

// ---- sim/seg_map_props.sv ----
// Concurrent checks on the ports of the data-memory segment mapper.
// Assumes the package is compiled first; attached to the top by bind.
`timescale 1ns/10ps
module seg_map_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire seg_map_pkg::mem_req_t req,
    input wire seg_map_pkg::mem_rsp_t rsp,
    input wire seg_map_pkg::ptr_regs_t ptrs
);
    import seg_map_pkg::*;
    logic dir_rd;
    assign dir_rd = req.valid && req.src == SRC_DIRECT && !req.stack_ref;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_rsp_follows: assert property (req.valid |=> rsp.valid)
        else $error("request gave no response");
    a_rsp_idle: assert property (!req.valid |=> !rsp.valid)
        else $error("response without request");
    a_upper_flat: assert property (dir_rd && req.direct_addr[7] |=>
        rsp.phys_addr == {8'h00, $past(req.direct_addr)}) else $error("upper half extended");
    a_lower_paged: assert property (dir_rd && !req.direct_addr[7] |=>
        rsp.phys_addr == {$past(ptrs.upper_page_reg), $past(req.direct_addr)})
        else $error("lower half not paged");
    a_stack_base: assert property (req.valid && req.stack_ref && req.op == OP_READ |=>
        rsp.phys_addr[15:8] == 8'h00 && $stable(ptrs.upper_page_reg))
        else $error("stack left segment zero");
    a_link_reset: assert property ($rose(rst_b) |-> ptrs.linkage_top_ptr == 8'h6F)
        else $error("linkage pointer reset value wrong");
    a_ram_inc: assert property (req.valid && req.src == SRC_RAM_PTR &&
        req.step == PTR_INC && req.op == OP_READ |=>
        ptrs.ram_pointer == $past(ptrs.ram_pointer) + 8'h01) else $error("no post increment");
    a_alt_dec: assert property (req.valid && req.src == SRC_ALT_PTR &&
        req.step == PTR_DEC && req.op == OP_READ |=>
        ptrs.alt_pointer == $past(ptrs.alt_pointer) - 8'h01) else $error("no post decrement");
    a_gap_ones: assert property (dir_rd && req.op == OP_READ &&
        req.direct_addr[7:4] == 4'h7 && ptrs.upper_page_reg == 8'h00 |=>
        rsp.rdata == 8'hFF) else $error("gap did not read ones");
    a_hop_zero: assert property (rsp.hop |-> rsp.valid && rsp.rdata == 8'h00)
        else $error("hop without zero result");
    c_hop: cover property (rsp.hop);
    c_stack: cover property (req.valid && req.stack_ref);
    c_alt: cover property (req.valid && req.src == SRC_ALT_PTR);
endmodule

bind data_memory_segment_mapper seg_map_props seg_map_props_inst (
    .clock(clock), .rst_b(rst_b), .req(req), .rsp(rsp), .ptrs(ptrs));

// ---- sim/tb_data_memory_segment_mapper.sv ----
// Self-checking bench for the data-memory segment mapper.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/10ps
module tb_data_memory_segment_mapper;
    import seg_map_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    mem_req_t cmd = '0;
    mem_req_t req;
    mem_rsp_t rsp;
    ptr_regs_t ptrs;
    int mismatches = 0;
    int n_checks = 0;
    always #20 clock = ~clock;
    cpu_req_model cpu_req_model_inst (.clock(clock), .cmd(cmd), .req(req));
    data_memory_segment_mapper data_memory_segment_mapper_inst (
        .clock(clock), .rst_b(rst_b), .req(req), .rsp(rsp), .ptrs(ptrs));
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input mem_op_t op, input addr_src_t src, input ptr_step_t st,
            input logic stk, input logic [7:0] a, input logic [7:0] wd, input logic [2:0] b);
        @(posedge clock);
        cmd <= '{1'b1, op, src, st, stk, a, wd, b};
        @(posedge clock);
        cmd.valid <= 1'b0;
        #1;
        chk("rsp_valid", {15'h0, rsp.valid}, 16'h0001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(OP_WRITE, SRC_DIRECT, PTR_KEEP, 1'b0, a, d, 3'h0);
    endtask
    task automatic rd(input logic [7:0] a);
        acc(OP_READ, SRC_DIRECT, PTR_KEEP, 1'b0, a, 8'h00, 3'h0);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_pages();
        wr(8'hFF, 8'h01);
        chk("page", {8'h00, ptrs.upper_page_reg}, 16'h0001);
        wr(8'h10, 8'hAA);
        chk("phys_seg1", rsp.phys_addr, 16'h0110);
        wr(8'hFF, 8'h00);
        wr(8'h10, 8'h55);
        chk("phys_seg0", rsp.phys_addr, 16'h0010);
        rd(8'h90);
        chk("phys_upper", rsp.phys_addr, 16'h0090);
        wr(8'h75, 8'h12);
        rd(8'h75);
        chk("gap_read", {8'h00, rsp.rdata}, 16'h00FF);
        wr(8'hFF, 8'h01);
        rd(8'h10);
        chk("seg1_data", {8'h00, rsp.rdata}, 16'h00AA);
        rd(8'hFF);
        chk("page_read", {8'h00, rsp.rdata}, 16'h0001);
        wr(8'hFF, 8'h00);
        rd(8'h10);
        chk("seg0_data", {8'h00, rsp.rdata}, 16'h0055);
    endtask
    task automatic t_regs();
        wr(8'hFC, 8'h30);
        wr(8'hFD, 8'h60);
        wr(8'hFE, 8'h20);
        chk("ptr_map", {ptrs.alt_pointer, ptrs.ram_pointer}, 16'h3020);
        chk("link_map", {8'h00, ptrs.linkage_top_ptr}, 16'h0060);
        acc(OP_LOAD_IMM, SRC_DIRECT, PTR_KEEP, 1'b0, 8'hF0, 8'h01, 3'h0);
        acc(OP_DEC_HOP, SRC_DIRECT, PTR_KEEP, 1'b0, 8'hF0, 8'h00, 3'h0);
        chk("hop", {7'h0, rsp.hop, rsp.rdata}, 16'h0100);
    endtask
    task automatic t_ptrs();
        acc(OP_WRITE, SRC_RAM_PTR, PTR_INC, 1'b0, 8'h00, 8'h77, 3'h0);
        chk("ram_ind", rsp.phys_addr, 16'h0020);
        chk("ram_inc", {8'h00, ptrs.ram_pointer}, 16'h0021);
        acc(OP_READ, SRC_ALT_PTR, PTR_DEC, 1'b0, 8'h00, 8'h00, 3'h0);
        chk("alt_dec", {rsp.phys_addr[7:0], ptrs.alt_pointer}, 16'h302F);
        acc(OP_READ, SRC_RAM_PTR, PTR_DEC, 1'b0, 8'h00, 8'h00, 3'h0);
        acc(OP_READ, SRC_RAM_PTR, PTR_KEEP, 1'b0, 8'h00, 8'h00, 3'h0);
        chk("ram_data", {ptrs.ram_pointer, rsp.rdata}, 16'h2077);
        acc(OP_READ, SRC_RAM_PTR, PTR_INC, 1'b0, 8'h00, 8'h00, 3'h0);
        chk("ram_rd_inc", {ptrs.ram_pointer, rsp.rdata}, 16'h2177);
    endtask
    task automatic t_stack();
        wr(8'hFF, 8'h01);
        acc(OP_READ, SRC_LINK_PTR, PTR_KEEP, 1'b1, 8'h00, 8'h00, 3'h0);
        chk("stack_addr", rsp.phys_addr, 16'h0060);
        chk("stack_page", {8'h00, ptrs.upper_page_reg}, 16'h0001);
        wr(8'hFF, 8'h00);
    endtask
    task automatic t_bits();
        wr(8'h05, 8'h00);
        acc(OP_BIT_SET, SRC_DIRECT, PTR_KEEP, 1'b0, 8'h05, 8'h00, 3'h3);
        acc(OP_BIT_TEST, SRC_DIRECT, PTR_KEEP, 1'b0, 8'h05, 8'h00, 3'h3);
        chk("bit_set", {7'h0, rsp.bit_value, rsp.rdata}, 16'h0108);
        acc(OP_BIT_CLR, SRC_DIRECT, PTR_KEEP, 1'b0, 8'h05, 8'h00, 3'h3);
        rd(8'h05);
        chk("bit_clr", {8'h00, rsp.rdata}, 16'h0000);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("link_reset", {8'h00, ptrs.linkage_top_ptr}, 16'h006F);
        t_pages();
        t_regs();
        t_ptrs();
        t_stack();
        t_bits();
        close_out();
    end
    // Roughly 30 accesses of two cycles each; the margin covers a stall.
    initial begin
        repeat (600) @(posedge clock);
        mismatches++;
        close_out();
    end
endmodule

// ---- verilog/data_memory_segment_mapper.sv ----
// Data-memory segment mapper: pointer registers, address forming and RAM access.
// Assumes the instruction datapath issues at most one request per instruction cycle.
`timescale 1ns/10ps
`include "seg_map_defines.svh"

module data_memory_segment_mapper (
    input wire logic clock,
    input wire logic rst_b,
    input wire seg_map_pkg::mem_req_t req,
    output seg_map_pkg::mem_rsp_t rsp,
    output seg_map_pkg::ptr_regs_t ptrs
);
    import seg_map_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ptr_regs_t regs;
        mem_rsp_t rsp;
    } state_t;

    state_t state_q;
    state_t state_d;

    // Only bytes F0 to FB are plain storage; FC to FF are the pointers.
    logic [7:0] reg_file_q [`REG_FILE_DEPTH];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = `BYTE_ONE << sel;
    endfunction

    function automatic logic [7:0] step_ptr(input logic [7:0] p, input ptr_step_t s);
        case (s)
            PTR_INC: step_ptr = p + `BYTE_ONE;
            PTR_DEC: step_ptr = p - `BYTE_ONE;
            default: step_ptr = p;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------
    logic [7:0] base_addr;
    logic [15:0] phys_addr;

    always_comb begin
        case (req.src)
            SRC_RAM_PTR: base_addr = state_q.regs.ram_pointer;
            SRC_ALT_PTR: base_addr = state_q.regs.alt_pointer;
            SRC_LINK_PTR: base_addr = state_q.regs.linkage_top_ptr;
            default: base_addr = req.direct_addr;
        endcase
    end

    seg_addr_map u_map (
        .base_addr(base_addr),
        .page(state_q.regs.upper_page_reg),
        .stack_ref(req.stack_ref || req.src == SRC_LINK_PTR),
        .phys_addr(phys_addr)
    );

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    logic in_low_ram;
    logic in_seg_ram;
    logic in_reg_file;
    logic [7:0] low_rdata;
    logic [7:0] seg_rdata;
    logic [7:0] cur_byte;
    logic [7:0] new_byte;
    logic do_write;

    always_comb begin
        in_low_ram = 1'b0;
        in_seg_ram = 1'b0;
        in_reg_file = 1'b0;
        if (phys_addr[15:8] == `PAGE_ZERO && phys_addr[7:0] <= `LOWER_RAM_LAST) begin
            in_low_ram = 1'b1;
        end else if (phys_addr[15:8] == `PAGE_ONE && !phys_addr[`UPPER_HALF_BIT]) begin
            in_seg_ram = 1'b1;
        end else if (phys_addr[15:8] == `PAGE_ZERO && phys_addr[7:0] >= `REG_FILE_BASE) begin
            in_reg_file = 1'b1;
        end
    end

    always_comb begin
        if (in_low_ram) begin
            cur_byte = low_rdata;
        end else if (in_seg_ram) begin
            cur_byte = seg_rdata;
        end else if (in_reg_file) begin
            if (phys_addr[7:0] == `ADDR_ALT_POINTER) begin
                cur_byte = state_q.regs.alt_pointer;
            end else if (phys_addr[7:0] == `ADDR_LINKAGE_TOP) begin
                cur_byte = state_q.regs.linkage_top_ptr;
            end else if (phys_addr[7:0] == `ADDR_RAM_POINTER) begin
                cur_byte = state_q.regs.ram_pointer;
            end else if (phys_addr[7:0] == `ADDR_UPPER_PAGE) begin
                cur_byte = state_q.regs.upper_page_reg;
            end else begin
                cur_byte = reg_file_q[phys_addr[3:0]];
            end
        end else begin
            // Other upper-half addresses belong to peripherals outside this block.
            cur_byte = `UNMAPPED_READ;
        end
    end

    // Accumulator and program counter have no decode here at all.
    always_comb begin
        new_byte = cur_byte;
        do_write = 1'b0;
        if (req.valid) begin
            case (req.op)
                OP_WRITE, OP_LOAD_IMM: begin
                    new_byte = req.wdata;
                    do_write = 1'b1;
                end
                OP_BIT_SET: begin
                    new_byte = cur_byte | bit_mask(req.bit_sel);
                    do_write = 1'b1;
                end
                OP_BIT_CLR: begin
                    new_byte = cur_byte & ~bit_mask(req.bit_sel);
                    do_write = 1'b1;
                end
                OP_DEC_HOP: begin
                    new_byte = cur_byte - `BYTE_ONE;
                    do_write = 1'b1;
                end
                default: begin
                    new_byte = cur_byte;
                    do_write = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // RAM banks
    // ------------------------------------------------------------
    seg_ram_bank #(.DEPTH(`LOWER_RAM_DEPTH)) u_low (
        .clock(clock),
        .we(do_write && in_low_ram),
        .addr(phys_addr[6:0]),
        .wdata(new_byte),
        .rdata(low_rdata)
    );

    seg_ram_bank #(.DEPTH(`SEG_RAM_DEPTH)) u_seg (
        .clock(clock),
        .we(do_write && in_seg_ram),
        .addr(phys_addr[6:0]),
        .wdata(new_byte),
        .rdata(seg_rdata)
    );

    always_ff @(posedge clock) begin
        if (do_write && in_reg_file && phys_addr[7:0] < `ADDR_ALT_POINTER) begin
            reg_file_q[phys_addr[3:0]] <= new_byte;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic ptr_write;

    always_comb begin
        state_d = state_q;
        state_d.rsp.valid = req.valid;
        state_d.rsp.hop = 1'b0;
        ptr_write = do_write && in_reg_file;
        if (req.valid) begin
            state_d.rsp.rdata = cur_byte;
            state_d.rsp.phys_addr = phys_addr;
            state_d.rsp.bit_value = cur_byte[req.bit_sel];
            if (req.op == OP_DEC_HOP) begin
                state_d.rsp.rdata = new_byte;
                state_d.rsp.hop = (new_byte == `BYTE_ZERO);
            end
            // Post step first, so an explicit write to the pointer itself wins.
            if (req.src == SRC_RAM_PTR) begin
                state_d.regs.ram_pointer = step_ptr(state_q.regs.ram_pointer, req.step);
            end else if (req.src == SRC_ALT_PTR) begin
                state_d.regs.alt_pointer = step_ptr(state_q.regs.alt_pointer, req.step);
            end
            if (ptr_write && phys_addr[7:0] == `ADDR_ALT_POINTER) begin
                state_d.regs.alt_pointer = new_byte;
            end else if (ptr_write && phys_addr[7:0] == `ADDR_LINKAGE_TOP) begin
                state_d.regs.linkage_top_ptr = new_byte;
            end else if (ptr_write && phys_addr[7:0] == `ADDR_RAM_POINTER) begin
                state_d.regs.ram_pointer = new_byte;
            end else if (ptr_write && phys_addr[7:0] == `ADDR_UPPER_PAGE) begin
                state_d.regs.upper_page_reg = new_byte;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
            state_q.regs.linkage_top_ptr <= `LINKAGE_TOP_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign rsp = state_q.rsp;
    assign ptrs = state_q.regs;
endmodule

// ---- verilog/seg_addr_map.sv ----
// Combinational mapping of a one-byte data address to a 16-bit physical address.
// Assumes the page register value comes from the caller's registers.
`timescale 1ns/10ps
`include "seg_map_defines.svh"
module seg_addr_map (
    input wire logic [7:0] base_addr,
    input wire logic [7:0] page,
    input wire logic stack_ref,
    output logic [15:0] phys_addr
);
    import seg_map_pkg::*;

    always_comb begin
        if (base_addr[`UPPER_HALF_BIT]) begin
            phys_addr = {`PAGE_ZERO, base_addr};
        end else if (stack_ref) begin
            phys_addr = {`PAGE_ZERO, base_addr};
        end else begin
            phys_addr = {page, base_addr};
        end
    end
endmodule

// ---- verilog/seg_map_defines.svh ----
// Address and reset constants of the data-memory segment mapper.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef SEG_MAP_DEFINES_SVH
`define SEG_MAP_DEFINES_SVH
`define ADDR_ALT_POINTER 8'hFC
`define ADDR_LINKAGE_TOP 8'hFD
`define ADDR_RAM_POINTER 8'hFE
`define ADDR_UPPER_PAGE 8'hFF
`define REG_FILE_BASE 8'hF0
`define LOWER_RAM_LAST 8'h6F
`define UPPER_HALF_BIT 7
`define LINKAGE_TOP_RESET 8'h6F
`define PAGE_ZERO 8'h00
`define PAGE_ONE 8'h01
`define UNMAPPED_READ 8'hFF
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00
`define LOWER_RAM_DEPTH 112
`define SEG_RAM_DEPTH 128
`define REG_FILE_DEPTH 16
`endif

// ---- verilog/seg_map_pkg.sv ----
// Types shared by the data-memory segment mapper and its helpers.
// Assumes the defines header sits beside it.
`include "seg_map_defines.svh"
package seg_map_pkg;
    typedef enum logic [2:0] {
        SRC_DIRECT = 3'b000,
        SRC_RAM_PTR = 3'b001,
        SRC_ALT_PTR = 3'b011,
        SRC_LINK_PTR = 3'b010
    } addr_src_t;

    typedef enum logic [1:0] {
        PTR_KEEP = 2'b00,
        PTR_INC = 2'b01,
        PTR_DEC = 2'b11
    } ptr_step_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_READ = 3'b001,
        OP_WRITE = 3'b011,
        OP_BIT_SET = 3'b010,
        OP_BIT_CLR = 3'b110,
        OP_BIT_TEST = 3'b111,
        OP_LOAD_IMM = 3'b101,
        OP_DEC_HOP = 3'b100
    } mem_op_t;

    typedef struct packed {
        logic valid;
        mem_op_t op;
        addr_src_t src;
        ptr_step_t step;
        logic stack_ref;
        logic [7:0] direct_addr;
        logic [7:0] wdata;
        logic [2:0] bit_sel;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic bit_value;
        logic hop;
        logic [15:0] phys_addr;
    } mem_rsp_t;

    typedef struct packed {
        logic [7:0] alt_pointer;
        logic [7:0] linkage_top_ptr;
        logic [7:0] ram_pointer;
        logic [7:0] upper_page_reg;
    } ptr_regs_t;
endpackage

// ---- verilog/seg_ram_bank.sv ----
// One bank of data RAM, written synchronously and read combinationally.
// Assumes the caller decodes which bank an access selects.
`timescale 1ns/10ps
module seg_ram_bank #(
    parameter int DEPTH = 128
) (
    input wire logic clock,
    input wire logic we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // Contents are left uninitialised on purpose: software must write first.
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule
